//--- hdl/smps_pkg.sv
// Shared constants and carrier types for the serial master poll scheduler.
// Assumes a 100 MHz sys_clk and a synchronous active-high reset in every user.
// ============================================================================
package smps_pkg;

	localparam int          CLK_PERIOD_NS = 10;
	localparam int          MS_NS         = 1000000;
	localparam int          CLKS_PER_MS   = MS_NS / CLK_PERIOD_NS;
	localparam int          CMD_IDX_W     = 8;
	localparam int          NUM_SLAVES    = 256;
	localparam logic [7:0]  NODE_MIN      = 8'h01;
	localparam logic [7:0]  NODE_MAX      = 8'hf7;
	localparam logic [14:0] FLOAT_START_MAX = 15'h7fff;
	localparam logic [11:0] FLOAT_OFF_MAX = 12'hf9e;
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_TIMEOUT   = 16'h00ff;
	localparam logic [15:0] TIMER_RST     = 16'h0000;

	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_SELECT = 7'h02,
		ST_RTS_ON = 7'h04,
		ST_SEND   = 7'h08,
		ST_RTS_OFF = 7'h10,
		ST_WAIT   = 7'h20,
		ST_GAP    = 7'h40
	} smps_state_t;

	typedef struct packed {
		logic        port_enable;
		logic        float_enable;
		logic [14:0] float_start;
		logic [11:0] float_offset;
		logic [7:0]  node_addr;
		logic [15:0] min_cmd_delay_ms;
		logic [15:0] command_error_base;
		logic [15:0] skip_limit;
		logic [15:0] resp_timeout_ms;
		logic [15:0] retry_limit;
		logic [15:0] rts_on_ms;
		logic [15:0] rts_off_ms;
		logic [CMD_IDX_W-1:0] cmd_count;
	} smps_cfg_t;

	typedef struct packed {
		logic        valid;
		logic [15:0] addr;
		logic [15:0] data;
	} smps_err_wr_t;

	typedef struct packed {
		smps_state_t          st;
		logic [CMD_IDX_W-1:0] idx;
		logic [15:0]          timer;
		logic [15:0]          retry;
		logic                 advance;
		logic                 rts;
		logic                 tx_start;
		smps_err_wr_t         err;
		logic [NUM_SLAVES-1:0] fail;
		logic [NUM_SLAVES-1:0][15:0] skip;
		logic                 float_en;
		logic [14:0]          float_start;
		logic [11:0]          float_off;
		logic [7:0]           node;
		logic                 node_ok;
		logic                 busy;
	} smps_state_s_t;

endpackage

//--- hdl/smps_ms_tick.sv
// Millisecond time base for the poll scheduler.
// Assumes one clock; restart realigns the period so a loaded delay is whole milliseconds.
`timescale 1ns/100ps
module smps_ms_tick #(
	parameter int CLKS_PER_MS = smps_pkg::CLKS_PER_MS
) (
	input  wire logic sys_clk,  // System clock.
	input  wire logic rst,      // Synchronous reset, active high.
	input  wire logic restart,  // Start a fresh millisecond.
	output logic      tick      // One-cycle pulse per millisecond.
);
	localparam int CW = $clog2(CLKS_PER_MS + 1);
	localparam logic [CW-1:0] LAST = CW'(CLKS_PER_MS - 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic          tick;
	} smps_tick_s_t;

	smps_tick_s_t t_q;
	smps_tick_s_t t_d;

	always_comb begin
		t_d      = t_q;
		t_d.tick = !restart && t_q.cnt == LAST;
		if (restart || t_q.cnt == LAST) begin
			t_d.cnt = '0;
		end else begin
			t_d.cnt = t_q.cnt + CW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			t_q <= '0;
		end else begin
			t_q <= t_d;
		end
	end

	assign tick = t_q.tick;
endmodule

//--- hdl/smps_sched.sv
// Command list poll scheduler for a serial master port.
// Assumes the command list, framer and receiver run on sys_clk and need no synchroniser.
`timescale 1ns/100ps
module smps_sched #(
	parameter int CLKS_PER_MS = smps_pkg::CLKS_PER_MS
) (
	input  wire logic                           sys_clk,       // System clock, 100 MHz.
	input  wire logic                           rst,           // Synchronous reset, active high.
	input  wire smps_pkg::smps_cfg_t            cfg,           // Port configuration.
	input  wire logic [7:0]                     cmd_slave,     // Slave address of entry cmd_index.
	input  wire logic                           tx_done,       // Last character sent, pulse.
	input  wire logic                           rx_reply,      // Reply received, pulse.
	input  wire logic [15:0]                    rx_error_code, // Error code of that reply.
	output logic [smps_pkg::CMD_IDX_W-1:0]      cmd_index,     // Current command entry.
	output logic                                tx_start,      // Start sending entry, pulse.
	output logic                                rts,           // Request to send, active high.
	output smps_pkg::smps_err_wr_t              err_wr,        // Error word write into database.
	output logic                                float_active,  // Float handling enabled.
	output logic [14:0]                         float_start,   // First float register in message.
	output logic [11:0]                         float_offset,  // Database address of floats.
	output logic [7:0]                          own_node,      // Port node address.
	output logic                                own_node_ok,   // Node address within range.
	output logic                                busy           // Scheduler not idle.
);
	smps_pkg::smps_state_s_t s_q;
	smps_pkg::smps_state_s_t s_d;
	logic                    tick;
	logic                    load;
	logic                    expired;
	logic [smps_pkg::CMD_IDX_W-1:0] next_idx;

	smps_ms_tick #(.CLKS_PER_MS(CLKS_PER_MS)) u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.restart (load),
		.tick    (tick)
	);

	assign expired  = s_q.timer == smps_pkg::TIMER_RST;
	assign next_idx = (s_q.idx + smps_pkg::CMD_IDX_W'(1) >= cfg.cmd_count) ? '0 :
		s_q.idx + smps_pkg::CMD_IDX_W'(1);

	// ========================================================================
	// Next state
	always_comb begin
		s_d           = s_q;
		load          = 1'b0;
		s_d.tx_start  = 1'b0;
		s_d.err.valid = 1'b0;
		s_d.float_en    = cfg.float_enable;
		s_d.float_start = (cfg.float_start > smps_pkg::FLOAT_START_MAX) ? smps_pkg::FLOAT_START_MAX :
			cfg.float_start;
		s_d.float_off   = (cfg.float_offset > smps_pkg::FLOAT_OFF_MAX) ? smps_pkg::FLOAT_OFF_MAX :
			cfg.float_offset;
		s_d.node    = cfg.node_addr;
		s_d.node_ok = cfg.node_addr >= smps_pkg::NODE_MIN && cfg.node_addr <= smps_pkg::NODE_MAX;
		if (tick && !expired) begin
			s_d.timer = s_q.timer - 16'h0001;
		end
		case (s_q.st)
			smps_pkg::ST_IDLE: begin
				s_d.rts = 1'b0;
				if (cfg.port_enable && cfg.cmd_count != '0) begin
					s_d.idx = (s_q.idx >= cfg.cmd_count) ? '0 : s_q.idx;
					s_d.st  = smps_pkg::ST_SELECT;
				end
			end
			smps_pkg::ST_SELECT: begin
				if (!cfg.port_enable) begin
					s_d.st = smps_pkg::ST_IDLE;
				end else if (s_q.fail[cmd_slave] && s_q.skip[cmd_slave] != cfg.skip_limit) begin
					// Slow poll: the entry is passed over and counted against its slave.
					s_d.skip[cmd_slave] = s_q.skip[cmd_slave] + 16'h0001;
					s_d.idx = next_idx;
				end else begin
					s_d.skip[cmd_slave] = 16'h0000;
					s_d.rts   = 1'b1;
					s_d.timer = cfg.rts_on_ms;
					load      = 1'b1;
					s_d.st    = smps_pkg::ST_RTS_ON;
				end
			end
			smps_pkg::ST_RTS_ON: begin
				if (expired) begin
					s_d.tx_start = 1'b1;
					s_d.st       = smps_pkg::ST_SEND;
				end
			end
			smps_pkg::ST_SEND: begin
				if (tx_done) begin
					s_d.timer = cfg.rts_off_ms;
					load      = 1'b1;
					s_d.st    = smps_pkg::ST_RTS_OFF;
				end
			end
			smps_pkg::ST_RTS_OFF: begin
				if (expired) begin
					s_d.rts   = 1'b0;
					s_d.timer = cfg.resp_timeout_ms;
					load      = 1'b1;
					s_d.st    = smps_pkg::ST_WAIT;
				end
			end
			smps_pkg::ST_WAIT: begin
				if (rx_reply) begin
					s_d.err.valid       = 1'b1;
					s_d.err.data        = rx_error_code;
					s_d.fail[cmd_slave] = 1'b0;
					s_d.retry   = 16'h0000;
					s_d.advance = 1'b1;
					s_d.timer   = cfg.min_cmd_delay_ms;
					load        = 1'b1;
					s_d.st      = smps_pkg::ST_GAP;
				end else if (expired) begin
					if (s_q.retry < cfg.retry_limit) begin
						s_d.retry   = s_q.retry + 16'h0001;
						s_d.advance = 1'b0;
					end else begin
						s_d.err.valid       = 1'b1;
						s_d.err.data        = smps_pkg::ERR_TIMEOUT;
						s_d.fail[cmd_slave] = 1'b1;
						s_d.skip[cmd_slave] = 16'h0000;
						s_d.retry   = 16'h0000;
						s_d.advance = 1'b1;
					end
					s_d.timer = cfg.min_cmd_delay_ms;
					load      = 1'b1;
					s_d.st    = smps_pkg::ST_GAP;
				end
				// The word index follows the entry, so a later base change moves only new writes.
				s_d.err.addr = cfg.command_error_base + {8'h00, s_q.idx};
			end
			smps_pkg::ST_GAP: begin
				if (expired) begin
					if (s_q.advance) begin
						s_d.idx = next_idx;
					end
					s_d.st = cfg.port_enable ? smps_pkg::ST_SELECT : smps_pkg::ST_IDLE;
				end
			end
			default: begin
				s_d.st = smps_pkg::ST_IDLE;
			end
		endcase
		// Busy follows the next state so the output comes from a flop without an extra cycle of lag.
		s_d.busy = s_d.st != smps_pkg::ST_IDLE;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '{st: smps_pkg::ST_IDLE, err: '{valid: 1'b0, addr: 16'h0000, data: 16'h0000},
				fail: '0, skip: '0, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	assign cmd_index    = s_q.idx;
	assign tx_start     = s_q.tx_start;
	assign rts          = s_q.rts;
	assign err_wr       = s_q.err;
	assign float_active = s_q.float_en;
	assign float_start  = s_q.float_start;
	assign float_offset = s_q.float_off;
	assign own_node     = s_q.node;
	assign own_node_ok  = s_q.node_ok;
	assign busy         = s_q.busy;

	// ========================================================================
	// Checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence s_timeout_last;
		s_q.st == smps_pkg::ST_WAIT && !rx_reply && expired && s_q.retry >= cfg.retry_limit;
	endsequence

	sequence s_timeout_retry;
		s_q.st == smps_pkg::ST_WAIT && !rx_reply && expired && s_q.retry < cfg.retry_limit;
	endsequence

	a_tx_under_rts: assert property (tx_start |-> rts && $past(s_q.st) == smps_pkg::ST_RTS_ON)
		else $error("transmit started without rts delay");
	a_rts_on_hold: assert property ((s_q.st == smps_pkg::ST_RTS_ON && !expired) |=> !tx_start && rts)
		else $error("transmit started before rts delay ended");
	a_rts_off_hold: assert property (s_q.st == smps_pkg::ST_RTS_OFF |-> rts)
		else $error("rts dropped before off delay ended");
	a_reply_err_word: assert property ((s_q.st == smps_pkg::ST_WAIT && rx_reply) |=>
		err_wr.valid && err_wr.data == $past(rx_error_code) &&
		err_wr.addr == $past(cfg.command_error_base) + {8'h00, cmd_index})
		else $error("reply error word wrong");
	a_retry_same_cmd: assert property (s_timeout_retry |=> !err_wr.valid && s_q.st == smps_pkg::ST_GAP &&
		!s_q.advance)
		else $error("retry did not reissue the command");
	a_retry_out_err: assert property (s_timeout_last |=> err_wr.valid && err_wr.data == smps_pkg::ERR_TIMEOUT &&
		s_q.advance)
		else $error("exhausted command did not advance");
	a_gap_waits: assert property ((s_q.st == smps_pkg::ST_GAP && !expired) |=> s_q.st == smps_pkg::ST_GAP)
		else $error("gap ended early");
	a_list_wraps: assert property ((s_q.st == smps_pkg::ST_GAP && expired && s_q.advance &&
		s_q.idx + smps_pkg::CMD_IDX_W'(1) == cfg.cmd_count) |=> cmd_index == '0)
		else $error("command list did not wrap");
	a_skip_resume: assert property ((s_q.st == smps_pkg::ST_SELECT && cfg.port_enable &&
		s_q.fail[cmd_slave] && s_q.skip[cmd_slave] == cfg.skip_limit) |=> s_q.st == smps_pkg::ST_RTS_ON)
		else $error("failed slave not retried after skips");
	a_skip_passes: assert property ((s_q.st == smps_pkg::ST_SELECT && cfg.port_enable &&
		s_q.fail[cmd_slave] && s_q.skip[cmd_slave] != cfg.skip_limit) |=> s_q.st == smps_pkg::ST_SELECT && !rts)
		else $error("failed slave polled during skip");
	a_node_range: assert property (##1 own_node_ok == ($past(cfg.node_addr) >= smps_pkg::NODE_MIN &&
		$past(cfg.node_addr) <= smps_pkg::NODE_MAX))
		else $error("node range flag wrong");
	a_float_limits: assert property (float_offset <= smps_pkg::FLOAT_OFF_MAX && (float_active == $past(cfg.float_enable)
		|| $past(rst)))
		else $error("float settings wrong");
	a_float_start: assert property (float_start == $past(cfg.float_start) || $past(rst))
		else $error("float start setting wrong");
	a_wait_rts_low: assert property (s_q.st == smps_pkg::ST_WAIT |-> !rts)
		else $error("rts still high while awaiting reply");
	a_wait_holds: assert property ((s_q.st == smps_pkg::ST_WAIT && !expired && !rx_reply) |=>
		s_q.st == smps_pkg::ST_WAIT)
		else $error("reply wait ended early");
	a_idle_quiet: assert property (s_q.st == smps_pkg::ST_IDLE |-> !rts && !tx_start && !busy)
		else $error("idle port still active");
endmodule

//--- sim/smps_slave_model.sv
// Behavioural serial slave that answers the poll scheduler.
// Assumes one sys_clk; the slave at dead_addr never replies.
`timescale 1ns/100ps
module smps_slave_model (
	input  wire logic       sys_clk,      // System clock.
	input  wire logic       rst,          // Synchronous reset.
	input  wire logic       tx_start,     // Frame start pulse.
	input  wire logic       rts,          // Request to send.
	input  wire logic [7:0] slave,        // Target address.
	input  wire logic [7:0] dead_addr,    // Silent slave.
	input  wire logic [7:0] reply_dly,    // Reply latency.
	output logic            tx_done,      // Last character out.
	output logic            rx_reply,     // Reply pulse.
	output logic [15:0]     rx_error_code // Reply code.
);
	logic       tx_busy;
	logic       wait_rts;
	logic       r_busy;
	logic [7:0] cnt;
	logic [7:0] who;
	// ==========
	// Frame and reply timing
	// The code bus toggles every cycle between replies, so a stale code shows again only on every other cycle.
	always @(posedge sys_clk) begin
		tx_done <= 1'b0;
		rx_reply <= 1'b0;
		rx_error_code <= ~rx_error_code;
		if (rst) begin
			tx_busy <= 1'b0;
			wait_rts <= 1'b0;
			r_busy <= 1'b0;
			rx_error_code <= 16'h0000;
		end else if (tx_start) begin
			tx_busy <= 1'b1;
			cnt <= 8'h04;
			who <= slave;
		end else if (tx_busy) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				tx_busy <= 1'b0;
				tx_done <= 1'b1;
				wait_rts <= (who != dead_addr);
			end
		end else if (wait_rts && !rts) begin
			wait_rts <= 1'b0;
			r_busy <= 1'b1;
			cnt <= reply_dly;
		end else if (r_busy) begin
			cnt <= cnt - 8'h01;
			if (cnt == 8'h00) begin
				r_busy <= 1'b0;
				rx_reply <= 1'b1;
				rx_error_code <= {8'h5a, who};
			end
		end
	end
endmodule

//--- sim/testbench.sv
// Self-checking bench for the poll scheduler with a behavioural slave.
// Assumes a 10 ns sys_clk and a millisecond shortened to 10 cycles.
`timescale 1ns/100ps
module testbench;
	localparam int         CPM     = 10;
	// Both waits are bounded at 3000 cycles each, so this ceiling only trips on a stuck bench.
	localparam int         CYC_LIMIT = 10000;
	localparam logic [3:0] NODE_OK = 4'b0110;
	logic                  sys_clk, rst, tx_done, rx_reply, tx_start, rts, float_active, own_node_ok, busy, rts_p;
	logic [15:0]           rx_error_code;
	logic [14:0]           float_start;
	logic [11:0]           float_offset;
	logic [7:0]            own_node, cmd_index, cmd_slave, dead_addr, reply_dly;
	smps_pkg::smps_cfg_t   cfg;
	smps_pkg::smps_err_wr_t err_wr;
	logic [7:0]            slave_tab [4] = '{8'h11, 8'h22, 8'h33, 8'h44};
	logic [7:0]            nodes [4] = '{8'h00, 8'h01, 8'hf7, 8'hf8};
	logic [7:0]            exp_seq [6] = '{8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
	int                    bad_count, n_compared, cyc, t_rts, t_done, t_err, d_on, d_off, d_gap, n_sent;
	logic [7:0]            sent_q [$];
	smps_pkg::smps_err_wr_t err_q [$];
	assign cmd_slave = slave_tab[cmd_index[1:0]];
	smps_sched #(.CLKS_PER_MS(CPM)) u_smps_sched (.sys_clk(sys_clk), .rst(rst), .cfg(cfg), .cmd_slave(cmd_slave),
		.tx_done(tx_done), .rx_reply(rx_reply), .rx_error_code(rx_error_code), .cmd_index(cmd_index),
		.tx_start(tx_start), .rts(rts), .err_wr(err_wr), .float_active(float_active), .float_start(float_start),
		.float_offset(float_offset), .own_node(own_node), .own_node_ok(own_node_ok), .busy(busy));
	smps_slave_model u_smps_slave_model (.sys_clk(sys_clk), .rst(rst), .tx_start(tx_start), .rts(rts),
		.slave(cmd_slave), .dead_addr(dead_addr), .reply_dly(reply_dly), .tx_done(tx_done), .rx_reply(rx_reply),
		.rx_error_code(rx_error_code));
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic do_reset(input int n);
		rst <= 1'b1;
		repeat (n) @(posedge sys_clk);
		rst <= 1'b0;
		sent_q.delete();
		err_q.delete();
	endtask
	task automatic wait_for(input int n);
		for (int k = 0; k < 3000 && sent_q.size() < n; k++) @(posedge sys_clk);
		check(32'(sent_q.size() >= n), 32'h1);
	endtask
	// ==========
	// Monitor
	// Delays are measured in whole cycles between the edges that launch and end them.
	always @(posedge sys_clk) begin
		if (cyc >= CYC_LIMIT) begin
			bad_count++;
			print_verdict();
		end
	end
	always @(posedge sys_clk) begin
		cyc = cyc + 1;
		if (rts && !rts_p) begin
			t_rts = cyc;
			d_gap = cyc - t_err;
		end
		if (!rts && rts_p) d_off = cyc - t_done;
		if (tx_start) begin
			d_on = cyc - t_rts;
			sent_q.push_back(cmd_index);
		end
		if (tx_done) t_done = cyc;
		if (err_wr.valid) begin
			t_err = cyc;
			err_q.push_back(err_wr);
		end
		rts_p = rts;
	end
	// ==========
	// Scenarios
	initial begin
		rst = 1'b1;
		cfg = '0;
		dead_addr = 8'h00;
		reply_dly = 8'h02;
		do_reset(12);
		@(posedge sys_clk);
		check({rts, tx_start, err_wr.valid, busy}, 4'h0);
		for (int i = 0; i < 4; i++) begin
			cfg.float_enable <= i[0];
			cfg.float_start <= 15'h7fff - 15'(i);
			cfg.float_offset <= 12'hf9c + 12'(i);
			cfg.node_addr <= nodes[i];
			repeat (2) @(posedge sys_clk);
			check(float_active, i[0]);
			check(float_start, 15'h7fff - 15'(i));
			check(float_offset, (i == 3) ? 12'hf9e : 12'hf9c + 12'(i));
			check({own_node, own_node_ok}, {nodes[i], NODE_OK[i]});
		end
		cfg.command_error_base <= 16'h0100;
		cfg.min_cmd_delay_ms <= 16'h0001;
		cfg.resp_timeout_ms <= 16'h0005;
		cfg.retry_limit <= 16'h0001;
		cfg.skip_limit <= 16'h0002;
		cfg.rts_on_ms <= 16'h0002;
		cfg.rts_off_ms <= 16'h0001;
		cfg.cmd_count <= 8'h03;
		cfg.port_enable <= 1'b1;
		wait_for(5);
		check(busy, 1'b1);
		for (int i = 0; i < 4; i++) begin
			check(sent_q[i], 8'(i % 3));
			check({err_q[i].addr, err_q[i].data}, {16'h0100 + 16'(i % 3), 8'h5a, slave_tab[i % 3]});
		end
		check(32'(d_on inside {[2 * CPM : 2 * CPM + 4]}), 32'h1);
		check(32'(d_off inside {[CPM : CPM + 4]}), 32'h1);
		check(32'(d_gap inside {[CPM : CPM + 4]}), 32'h1);
		dead_addr <= 8'h11;
		reply_dly <= 8'h28;
		cfg.cmd_count <= 8'h02;
		do_reset(2);
		wait_for(6);
		for (int i = 0; i < 6; i++) check(sent_q[i], exp_seq[i]);
		check({err_q[0].addr, err_q[0].data}, {16'h0100, smps_pkg::ERR_TIMEOUT});
		check(err_q.size(), 4);
		cfg.port_enable <= 1'b0;
		repeat (200) @(posedge sys_clk);
		n_sent = sent_q.size();
		check(busy, 1'b0);
		repeat (50) @(posedge sys_clk);
		check(sent_q.size(), n_sent);
		print_verdict();
	end
endmodule
